// ==== design/expander_defines.svh ====
// Constants for the sixteen-pin serial expander
`ifndef EXPANDER_DEFINES_SVH
`define EXPANDER_DEFINES_SVH

`define PIN_COUNT     16
`define BIT_LIMIT     5'h10
`define LATCH_RESET   16'hffff
`define SNAP_DEPTH    16

`endif

// ==== design/expander_pkg.sv ====
// Types for the expander; its snapshot buffer uses none of them
`include "expander_defines.svh"

package expander_pkg;

	typedef enum logic [2:0] {
		PH_IDLE  = 3'b001,
		PH_SHIFT = 3'b010,
		PH_DONE  = 3'b100
	} phase_e;

	typedef struct packed {
		logic                     link_clk;
		logic                     sel_n;
		logic                     serial_in;
		logic                     float_n;
		logic [`PIN_COUNT-1:0]    pins;
	} pin_s;

	typedef struct packed {
		pin_s                     meta;
		pin_s                     sync;
		logic                     clk_prev;
		logic                     sel_prev;
		phase_e                   phase;
		logic [4:0]               rcnt;
		logic [4:0]               fcnt;
		logic [`PIN_COUNT-1:0]    cap_sh;
		logic [`PIN_COUNT-1:0]    rx_sh;
		logic [`PIN_COUNT-1:0]    latch;
		logic                     so_bit;
		logic                     so_en;
	} core_s;

	typedef struct packed {
		logic [4:0]               wr_ptr;
		logic [4:0]               rd_ptr;
	} fifo_s;

endpackage

// ==== design/snap_fifo.sv ====
// Parameterised valid/ready FIFO for captured pin words
`timescale 1ns/1ps

module snap_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk,
	input  wire logic             srst,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_ff;
	logic [AW:0]      rd_ptr_ff;
	logic [AW:0]      nxt_wr_ptr;
	logic [AW:0]      nxt_rd_ptr;
	logic             push;
	logic             pop;

	// Extra pointer bit tells full from empty
	assign in_ready  = (wr_ptr_ff[AW] == rd_ptr_ff[AW]) || (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]);
	assign out_valid = (wr_ptr_ff != rd_ptr_ff);
	assign out_data  = mem[rd_ptr_ff[AW-1:0]];
	assign push      = ce && in_valid && in_ready;
	assign pop       = ce && out_valid && out_ready;

	always_comb begin
		nxt_wr_ptr = push ? wr_ptr_ff + {{AW{1'b0}}, 1'b1} : wr_ptr_ff;
		nxt_rd_ptr = pop ? rd_ptr_ff + {{AW{1'b0}}, 1'b1} : rd_ptr_ff;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr_ff[AW-1:0]] <= in_data;
		end
	end

endmodule // snap_fifo

// ==== design/serial_io_expander_16bit.sv ====
// Sixteen-pin serial expander: capture and receive shifters, output latch, open-drain pins
`timescale 1ns/1ps
`include "expander_defines.svh"

module serial_io_expander_16bit (
	input  wire logic                  sys_clk,
	input  wire logic                  srst,
	input  wire logic                  ce,
	input  wire logic                  link_clk,
	input  wire logic                  sel_n,
	input  wire logic                  serial_in,
	input  wire logic                  float_n,
	input  wire logic [`PIN_COUNT-1:0] parallel_pins_i,
	output logic      [`PIN_COUNT-1:0] parallel_pins_o,
	output logic      [`PIN_COUNT-1:0] parallel_pins_oe_n,
	output logic                       serial_out_i,
	output logic                       serial_out_o,
	output logic                       serial_out_oe_n,
	output logic                       snap_room,
	output logic                       snap_valid,
	input  wire logic                  snap_ready,
	output logic      [`PIN_COUNT-1:0] snap_data
);
	expander_pkg::core_s st_ff;
	expander_pkg::core_s nxt_st;
	expander_pkg::pin_s  pin_now;
	expander_pkg::core_s rst_st;

	logic                  sel_fall;
	logic                  sel_rise;
	logic                  clk_rise;
	logic                  clk_fall;
	logic [`PIN_COUNT-1:0] pin_and;

	assign pin_now = '{link_clk: link_clk, sel_n: sel_n, serial_in: serial_in, float_n: float_n,
		pins: parallel_pins_i};

	always_comb begin
		rst_st          = '0;
		// The link clock idles high; a low start would show a false rising edge
		rst_st.meta     = '{link_clk: 1'b1, sel_n: 1'b1, serial_in: 1'b1, float_n: 1'b0, pins: '1};
		rst_st.sync     = rst_st.meta;
		rst_st.clk_prev = 1'b1;
		rst_st.sel_prev = 1'b1;
		rst_st.phase    = expander_pkg::PH_IDLE;
		rst_st.latch    = `LATCH_RESET;
	end

	// Edges come only from the second synchroniser stage
	assign sel_fall = st_ff.sel_prev && !st_ff.sync.sel_n;
	assign sel_rise = !st_ff.sel_prev && st_ff.sync.sel_n;
	assign clk_rise = !st_ff.clk_prev && st_ff.sync.link_clk;
	assign clk_fall = st_ff.clk_prev && !st_ff.sync.link_clk;
	assign pin_and  = st_ff.sync.pins & st_ff.latch;

	always_comb begin
		nxt_st          = st_ff;
		nxt_st.meta     = pin_now;
		nxt_st.sync     = st_ff.meta;
		nxt_st.clk_prev = st_ff.sync.link_clk;
		nxt_st.sel_prev = st_ff.sync.sel_n;
		if (sel_fall) begin
			nxt_st.phase  = expander_pkg::PH_SHIFT;
			nxt_st.rcnt   = '0;
			nxt_st.fcnt   = '0;
			nxt_st.cap_sh = pin_and;
			nxt_st.so_en  = 1'b0;
		end else if (sel_rise) begin
			// A short frame latches whatever has arrived so far
			nxt_st.latch = st_ff.rx_sh;
			nxt_st.so_en = 1'b0;
			nxt_st.phase = expander_pkg::PH_IDLE;
		end else begin
			unique case (st_ff.phase)
				expander_pkg::PH_IDLE: begin
					nxt_st.so_en = 1'b0;
				end
				expander_pkg::PH_SHIFT: begin
					if (clk_rise && st_ff.rcnt < `BIT_LIMIT) begin
						// Right shift puts the first bit at pin 0
						nxt_st.rx_sh = {st_ff.sync.serial_in, st_ff.rx_sh[`PIN_COUNT-1:1]};
						nxt_st.rcnt  = st_ff.rcnt + 5'h01;
					end
					if (clk_fall) begin
						if (st_ff.fcnt < `BIT_LIMIT) begin
							nxt_st.so_bit = st_ff.cap_sh[0];
							nxt_st.so_en  = 1'b1;
							nxt_st.cap_sh = {1'b1, st_ff.cap_sh[`PIN_COUNT-1:1]};
							nxt_st.fcnt   = st_ff.fcnt + 5'h01;
						end else begin
							nxt_st.so_en = 1'b0;
							nxt_st.phase = expander_pkg::PH_DONE;
						end
					end
				end
				expander_pkg::PH_DONE: begin
					nxt_st.so_en = 1'b0;
				end
				default: begin
					nxt_st.phase = expander_pkg::PH_IDLE;
					nxt_st.so_en = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_ff <= rst_st;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// Open-drain pins: data is always low, enables decide
	assign parallel_pins_o    = '0;
	assign parallel_pins_oe_n = st_ff.latch | {`PIN_COUNT{~st_ff.sync.float_n}};
	assign serial_out_o       = 1'b0;
	assign serial_out_oe_n    = ~(st_ff.so_en && !st_ff.so_bit && st_ff.sync.float_n);
	assign serial_out_i       = st_ff.so_en ? st_ff.so_bit : 1'b1;

	// Every frame's pin snapshot is also offered to local logic; a full buffer drops it
	snap_fifo #(
		.WIDTH (`PIN_COUNT),
		.DEPTH (`SNAP_DEPTH)
	) u_snap_fifo (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.ce        (ce),
		.in_valid  (sel_fall),
		.in_ready  (snap_room),
		.in_data   (pin_and),
		.out_valid (snap_valid),
		.out_ready (snap_ready),
		.out_data  (snap_data)
	);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	property p_start;
		ce && sel_fall |=> st_ff.phase == expander_pkg::PH_SHIFT && st_ff.rcnt == 5'h00 && st_ff.fcnt == 5'h00;
	endproperty
	a_start: assert property (p_start) else $error("select fall did not start a frame");

	property p_capture;
		ce && sel_fall |=> st_ff.cap_sh == $past(st_ff.sync.pins & st_ff.latch);
	endproperty
	a_capture: assert property (p_capture) else $error("capture word is not pins AND latch");

	property p_shift_out;
		ce && !sel_rise && !sel_fall && st_ff.phase == expander_pkg::PH_SHIFT && clk_fall && st_ff.fcnt < 5'h10
		|=> st_ff.so_en && st_ff.so_bit == $past(st_ff.cap_sh[0]);
	endproperty
	a_shift_out: assert property (p_shift_out) else $error("serial output bit wrong after falling clock");

	property p_shift_in;
		ce && !sel_rise && !sel_fall && st_ff.phase == expander_pkg::PH_SHIFT && clk_rise && st_ff.rcnt < 5'h10
		|=> st_ff.rx_sh[15] == $past(st_ff.sync.serial_in) && st_ff.rcnt == $past(st_ff.rcnt) + 5'h01;
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("serial input not shifted on rising clock");

	property p_extra_clock;
		ce && !sel_rise && st_ff.rcnt == 5'h10 && clk_rise |=> $stable(st_ff.rx_sh) && st_ff.rcnt == 5'h10;
	endproperty
	a_extra_clock: assert property (p_extra_clock) else $error("clock beyond sixteen altered receive word");

	property p_release;
		ce && !sel_rise && !sel_fall && st_ff.phase == expander_pkg::PH_SHIFT && clk_fall && st_ff.fcnt == 5'h10
		|=> !st_ff.so_en && serial_out_oe_n && st_ff.phase == expander_pkg::PH_DONE;
	endproperty
	a_release: assert property (p_release) else $error("seventeenth falling clock left serial output active");

	property p_latch;
		ce && sel_rise |=> st_ff.latch == $past(st_ff.rx_sh) ##1 parallel_pins_oe_n[0] == (st_ff.latch[0] |
			~st_ff.sync.float_n);
	endproperty
	a_latch: assert property (p_latch) else $error("select rise did not load the latch");

	property p_early;
		ce && sel_rise && st_ff.rcnt < 5'h10 |=> !st_ff.so_en && serial_out_oe_n && st_ff.phase == expander_pkg::PH_IDLE;
	endproperty
	a_early: assert property (p_early) else $error("short frame left serial output active");

	property p_direction;
		st_ff.sync.float_n |-> parallel_pins_oe_n == st_ff.latch;
	endproperty
	a_direction: assert property (p_direction) else $error("pin enable does not follow latch");

	property p_open_drain;
		!serial_out_oe_n |-> st_ff.so_en && !st_ff.so_bit && serial_out_o == 1'b0 && parallel_pins_o == '0;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("output driven while not pulling low");

	property p_float;
		!st_ff.sync.float_n |-> serial_out_oe_n && (&parallel_pins_oe_n);
	endproperty
	a_float: assert property (p_float) else $error("float low did not release outputs");

	// Only a full buffer may drop a frame's snapshot
	property p_snap_push;
		ce && sel_fall && snap_room |=> snap_valid;
	endproperty
	a_snap_push: assert property (p_snap_push) else $error("frame snapshot not queued");

	c_full_frame: cover property (ce && sel_rise && st_ff.rcnt == 5'h10);
	c_short_frame: cover property (ce && sel_rise && st_ff.rcnt < 5'h10);
	c_seventeenth: cover property (st_ff.phase == expander_pkg::PH_DONE);
	c_snap_full: cover property (!snap_room);
	c_float_drop: cover property (ce && !st_ff.sync.float_n && $past(st_ff.sync.float_n));

endmodule // serial_io_expander_16bit

// ==== bench/host_model.sv ====
// Host side of the serial link: one frame per call
`timescale 1ns/1ps

module host_model (
	input  wire logic sys_clk,
	input  wire logic so_wire,
	output logic      link_clk,
	output logic      sel_n,
	output logic      serial_in
);
	task automatic gap(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// More than sixteen pulses are allowed so that overrun can be tried
	task automatic frame(input logic [16:0] tx, input int n, output logic [16:0] rx);
		rx = 17'h1ffff;
		sel_n = 1'b0;
		gap(8);
		for (int i = 0; i < n; i++) begin
			link_clk = 1'b0;
			serial_in = tx[i];
			gap(4);
			link_clk = 1'b1;
			gap(3);
			rx[i] = so_wire;
			gap(1);
		end
		gap(4);
		sel_n = 1'b1;
		serial_in = ~serial_in; // Data is meaningless once deselected
		gap(8);
	endtask

	initial begin
		link_clk  = 1'b1; // Clock stands still between frames
		sel_n     = 1'b1;
		serial_in = 1'b0;
	end
endmodule // host_model

// ==== bench/serial_io_expander_16bit_bench.sv ====
// Self-checking bench for the sixteen-pin serial expander
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module serial_io_expander_16bit_bench;
	logic        sys_clk, srst, float_n, snap_ready, link_clk, sel_n, serial_in;
	logic        so_i, so_o, so_oe_n, snap_room, snap_valid;
	logic [15:0] ext_low, pins_o, pins_oe_n, snap_data, last_rx;
	logic [16:0] rx;
	logic [15:0] snaps[$];
	int          mismatches = 0;
	int          cmp_count = 0;
	wire  [15:0] pin_wire = pins_oe_n & ~ext_low; // Pulled up unless someone pulls low

	serial_io_expander_16bit u_serial_io_expander_16bit (
		.sys_clk(sys_clk), .srst(srst), .ce(1'b1), .link_clk(link_clk), .sel_n(sel_n),
		.serial_in(serial_in), .float_n(float_n), .parallel_pins_i(pin_wire),
		.parallel_pins_o(pins_o), .parallel_pins_oe_n(pins_oe_n), .serial_out_i(so_i),
		.serial_out_o(so_o), .serial_out_oe_n(so_oe_n), .snap_room(snap_room),
		.snap_valid(snap_valid), .snap_ready(snap_ready), .snap_data(snap_data));

	host_model u_host_model (
		.sys_clk(sys_clk), .so_wire(so_oe_n), .link_clk(link_clk), .sel_n(sel_n), .serial_in(serial_in));

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// One frame; checks the word read back and the latch left behind
	task automatic xfer(input logic [16:0] tx, input int n);
		logic [15:0] exp_cap;
		logic [15:0] exp_rx;
		exp_cap = last_rx & ~ext_low;
		exp_rx = last_rx;
		if (snaps.size() < 16) snaps.push_back(exp_cap); // Full FIFO drops the word
		u_host_model.frame(tx, n, rx);
		for (int i = 0; i < n && i < 16; i++) begin
			`CHK(rx[i], exp_cap[i])
			exp_rx = {tx[i], exp_rx[15:1]};
		end
		if (n > 16) `CHK(rx[16], 1'b1)
		last_rx = exp_rx;
		`CHK(pins_oe_n, exp_rx)
		`CHK(so_oe_n, 1'b1)
		`CHK(so_i, 1'b1)
	endtask

	task automatic t_reset();
		repeat (4) @(negedge sys_clk);
		`CHK(pins_oe_n, 16'hffff)
		`CHK({so_oe_n, snap_valid, snap_room}, 3'h5)
		`CHK({pins_o, so_o}, 17'h00000)
		$display("reset test done");
	endtask

	task automatic t_write();
		xfer(17'h0a5c3, 16);
		ext_low = 16'h00f0;
		xfer(17'h07fff, 16);
		$display("write test done");
	endtask

	task automatic t_overrun();
		xfer(17'h11234, 17); // Top bit rides on the ignored seventeenth pulse
		$display("overrun test done");
	endtask

	task automatic t_short();
		xfer(17'h000a5, 8);
		$display("short frame test done");
	endtask

	task automatic t_float();
		float_n = 1'b0;
		repeat (8) @(negedge sys_clk);
		`CHK({pins_oe_n, so_oe_n}, 17'h1ffff)
		float_n = 1'b1;
		repeat (8) @(negedge sys_clk);
		`CHK(pins_oe_n, last_rx)
		$display("float test done");
	endtask

	// Fills the snapshot FIFO past full with a stalled reader, then drains it
	task automatic t_fifo();
		for (int i = 0; i < 13; i++) xfer(17'h00000, 0);
		`CHK(snap_room, 1'b0)
		snap_ready = 1'b1;
		for (int i = 0; i < 40 && snaps.size() > 0; i++) begin
			if (snap_valid === 1'b1) begin
				`CHK(snap_data, snaps.pop_front())
			end
			@(negedge sys_clk);
		end
		@(negedge sys_clk);
		`CHK(snaps.size(), 0)
		`CHK(snap_valid, 1'b0)
		$display("snapshot test done");
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	initial begin
		srst = 1'b1;
		float_n = 1'b1;
		snap_ready = 1'b0;
		ext_low = 16'h0000;
		last_rx = 16'hffff;
		repeat (16) @(negedge sys_clk);
		srst = 1'b0;
		t_reset();
		t_write();
		t_overrun();
		t_short();
		t_float();
		t_fifo();
		end_of_test();
	end

	initial begin
		repeat (100000) @(posedge sys_clk);
		mismatches++;
		end_of_test();
	end
endmodule // serial_io_expander_16bit_bench
